/* inc/rss_pkg.sv */
// constants, config layout, states and causes of the reset source sequencer
// assumes one 250 MHz core clock; the slow oscillator is derived from it
package rss_pkg;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned WDT_OSC_HZ   = 15_000;
  // rounded down: the derived oscillator never runs slow
  localparam int unsigned OSC_DIV      = CLK_HZ / WDT_OSC_HZ;
  localparam int unsigned POWERUP_DELAY_TIMER_MS      = 64;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS   = POWERUP_DELAY_TIMER_MS * WDT_OSC_HZ / 1000;
  localparam int unsigned WDT_BASE_MS  = 17;
  localparam int unsigned WDT_TICKS    = WDT_BASE_MS * WDT_OSC_HZ / 1000;
  localparam int unsigned OST_CYC      = 1024;
  localparam int unsigned PIN_FILT_NS  = 2000;
  localparam int unsigned BOR_FILT_NS  = 1000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int unsigned PIN_FILT_CYC = (PIN_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOR_FILT_CYC = (BOR_FILT_NS * CLK_MHZ + 999) / 1000;

  localparam logic [9:0]  POWERUP_DELAY_TIMER_LAST = 10'(POWERUP_DELAY_TIMER_TICKS - 1);
  localparam logic [7:0]  WDT_LAST  = 8'(WDT_TICKS - 1);
  localparam logic [10:0] OST_LAST  = 11'(OST_CYC - 1);
  localparam logic [9:0]  PIN_LAST  = 10'(PIN_FILT_CYC - 1);
  localparam logic [9:0]  BOR_LAST  = 10'(BOR_FILT_CYC - 1);

  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_OPT  = 8'h04;
  localparam logic [7:0] ADDR_PCON = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_CMD  = 8'h10;

  localparam int OPT_PSA_BIT    = 3;
  localparam int PCON_BOR_BIT   = 0;
  localparam int PCON_POR_BIT   = 1;
  localparam int STAT_PD_BIT    = 3;
  localparam int STAT_TO_BIT    = 4;
  localparam int STAT_CAUSE_LSB = 8;
  localparam int STAT_STATE_LSB = 12;
  localparam int CMD_CLR_BIT    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       xtal;       // crystal clock: wake needs start-up count
    logic       borLevel;   // brownout_level_sel
    logic [1:0] brownout_enable_cfg;      // brownout_enable_cfg
    logic       pwrtDis;    // powerup_delay_disable
    logic       extPinSel;  // ext_reset_pin_select
    logic       wdtEn;      // watchdog_enable_cfg
  } rss_cfg_t;

  localparam rss_cfg_t   CFG_RST  = 7'h1b;
  localparam logic [3:0] OPT_RST  = 4'hf;
  localparam logic [1:0] PCON_RST = 2'h1;
  // synchroniser idle values: pin high, supply low flag clear, supply ok clear
  localparam logic [2:0] SYNC_RST = 3'h4;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_POWERUP_DELAY_TIMER  = 3'h1,
    ST_OST   = 3'h3,
    ST_RUN   = 3'h2,
    ST_SLEEP = 3'h6,
    ST_WAKE  = 3'h7
  } rss_state_t;

  typedef enum logic [2:0] {
    CS_POR       = 3'h0,
    CS_BOR       = 3'h1,
    CS_WDT_RUN   = 3'h2,
    CS_WDT_SLEEP = 3'h3,
    CS_PIN_RUN   = 3'h4,
    CS_PIN_SLEEP = 3'h5
  } rss_cause_t;
endpackage : rss_pkg

/* rtl/rss_reset_sequencer.sv */
// reset source sequencer: supply, pin and watchdog resets, start-up timers
// assumes analog detectors and the pin are asynchronous; core signals are on clk
// Function
// - record six distinct reset causes
// - retained registers reset only on power-on
// - watchdog wake resumes without resetting registers
// - timeout and powerdown flags encode the cause
// - reset restarts at zero, wake continues
// - irq wake with enable vectors after next
// - unimplemented status bits read as zero
// - reset pin path filters short pulses
// - never drive the reset pin
// - pin select: internal reset or pin
// - hold reset while supply inadequate
// - power-up delay after supply resets only
// - config bit disables the power-up delay
// - watchdog shares eight-bit prescaler, selectable period
// - watchdog clocked from slow oscillator
// - watchdog held during oscillator start-up count
// - enabled watchdog runs through sleep
// - watchdog clear conditions
// - two-bit brown-out mode select
// - brown-out level select bit
// - filtered low supply resets, restarts delay
// - flash erase forces brown-out at lowest
// - supply, then delay, then start-up count
// - power-on status cleared only by power-on
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned OSC_DIV_P = OSC_DIV
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        porOkIn,
  input  wire logic        lowSupplyIn,
  input  wire logic        extResetPinIn,
  input  wire logic        sleepIn,
  input  wire logic        clrWdtIn,
  input  wire logic        oscFailIn,
  input  wire logic        flashEraseIn,
  input  wire logic        irqWakeIn,
  input  wire logic        gieIn,
  output logic             coreRstQ,
  output logic             porRstQ,
  output logic             resumeQ,
  output logic             vectorQ,
  output logic             sleepingQ,
  output logic             borEnQ,
  output logic             borLevelQ,
  output logic             extPinOutQ,
  output logic             extPinOeQ,
  output logic             extPinPullupQ,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  localparam int NS = 3;

  rss_cfg_t    cfgQ;
  logic [3:0]  optQ;
  logic [1:0]  pconQ;
  rss_state_t  stateQ, stateD;
  rss_cause_t  causeQ;
  logic        toQ, pdQ, wakeIrqQ;
  logic [NS-1:0] lvl;
  logic        pinRstQ, pinPrevQ, borRstQ;
  logic [9:0]  pinCntQ, borCntQ;
  logic [14:0] oscCntQ;
  logic        oscTickQ;
  logic [9:0]  pwrtCntQ;
  logic [10:0] ostCntQ;
  logic [7:0]  baseCntQ, preCntQ;
  logic        awHaveQ, wHaveQ;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic        wStrb0Q;

  // 3-flop synchronisers; a level counts once stages two and three agree
  for (genvar gi = 0; gi < NS; gi++) begin : g_sync
    logic s1Q, s2Q, s3Q, lvQ;
    always_ff @(posedge clk) begin
      if (rst) begin
        s1Q <= SYNC_RST[gi];
        s2Q <= SYNC_RST[gi];
        s3Q <= SYNC_RST[gi];
        lvQ <= SYNC_RST[gi];
      end else begin
        s1Q <= (gi == 0) ? porOkIn : (gi == 1) ? lowSupplyIn : extResetPinIn;
        s2Q <= s1Q;
        s3Q <= s2Q;
        if (s2Q == s3Q) begin
          lvQ <= s3Q;
        end
      end
    end
    assign lvl[gi] = lvQ;
  end

  wire porLow   = !lvl[0];
  wire sleeping = (stateQ == ST_SLEEP);
  // flash erase overrides the mode and the level
  wire borOn    = flashEraseIn || (cfgQ.brownout_enable_cfg == 2'h3) ||
                  (cfgQ.brownout_enable_cfg == 2'h2 && !sleeping);
  wire pinRaw   = cfgQ.extPinSel && !lvl[2];
  wire borRaw   = borOn && lvl[1];

  // reset pin noise filter, both edges need a stable width
  always_ff @(posedge clk) begin
    if (rst) begin
      pinCntQ  <= '0;
      pinRstQ  <= 1'b0;
      pinPrevQ <= 1'b0;
    end else begin
      pinPrevQ <= pinRstQ;
      if (pinRaw == pinRstQ) begin
        pinCntQ <= '0;
      end else if (pinCntQ == PIN_LAST) begin
        pinCntQ <= '0;
        pinRstQ <= pinRaw;
      end else begin
        pinCntQ <= pinCntQ + 10'h001;
      end
    end
  end

  // brown-out qualifier: only a dip longer than the filter time counts
  always_ff @(posedge clk) begin
    if (rst) begin
      borCntQ <= '0;
      borRstQ <= 1'b0;
    end else if (!borRaw) begin
      borCntQ <= '0;
      borRstQ <= 1'b0;
    end else if (borCntQ == BOR_LAST) begin
      borRstQ <= 1'b1;
    end else begin
      borCntQ <= borCntQ + 10'h001;
    end
  end

  // slow oscillator tick derived from clk
  always_ff @(posedge clk) begin
    if (rst || oscCntQ == 15'(OSC_DIV_P - 1)) begin
      oscCntQ  <= '0;
      oscTickQ <= !rst;
    end else begin
      oscCntQ  <= oscCntQ + 15'h0001;
      oscTickQ <= 1'b0;
    end
  end

  wire pwrtDone = oscTickQ && (pwrtCntQ == POWERUP_DELAY_TIMER_LAST);
  wire ostDone  = !cfgQ.xtal || (ostCntQ == OST_LAST);

  always_ff @(posedge clk) begin
    if (rst || stateQ != ST_POWERUP_DELAY_TIMER) begin
      pwrtCntQ <= '0;
    end else if (oscTickQ) begin
      pwrtCntQ <= pwrtCntQ + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (stateQ != ST_OST && stateQ != ST_WAKE)) begin
      ostCntQ <= '0;
    end else if (!ostDone) begin
      ostCntQ <= ostCntQ + 11'h001;
    end
  end

  // watchdog: base period, then the shared prescaler when assigned to it
  wire       wrGo   = awHaveQ && wHaveQ;
  wire       cmdClr = wrGo && wStrb0Q && awAddrQ == ADDR_CMD && wDataQ[CMD_CLR_BIT];
  wire       inStart = (stateQ == ST_HOLD) || (stateQ == ST_POWERUP_DELAY_TIMER) ||
                      (stateQ == ST_OST) || (stateQ == ST_WAKE);
  wire       wdtClr = !cfgQ.wdtEn || clrWdtIn || cmdClr || oscFailIn ||
                      inStart;
  wire [7:0] preMax = optQ[OPT_PSA_BIT] ? (8'h7f >> (3'h7 - optQ[2:0])) : 8'h00;
  wire       baseTick = oscTickQ && (baseCntQ == WDT_LAST);
  wire       wdtFire  = !wdtClr && baseTick && (preCntQ == preMax);
  // wake clear kept out of the fire term, else fire, wake and clear form a loop
  wire       wakeEv   = sleeping && (wdtFire || irqWakeIn);

  // sleep is not a clear term, so the count carries across it
  always_ff @(posedge clk) begin
    if (rst || wdtClr || (wakeEv && !cfgQ.xtal)) begin
      baseCntQ <= '0;
      preCntQ  <= '0;
    end else if (baseTick) begin
      baseCntQ <= '0;
      preCntQ  <= (preCntQ == preMax) ? 8'h00 : preCntQ + 8'h01;
    end else if (oscTickQ) begin
      baseCntQ <= baseCntQ + 8'h01;
    end
  end

  wire pinRise = pinRstQ && !pinPrevQ;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_HOLD: begin
        if (!porLow && !borRstQ) begin
          stateD = (causeQ inside {CS_POR, CS_BOR} && !cfgQ.pwrtDis) ?
                   ST_POWERUP_DELAY_TIMER : ST_OST;
        end
      end
      ST_POWERUP_DELAY_TIMER:  stateD = pwrtDone ? ST_OST : ST_POWERUP_DELAY_TIMER;
      ST_OST:   stateD = ostDone ? ST_RUN : ST_OST;
      ST_RUN: begin
        if (pinRise) begin
          stateD = ST_OST;
        end else if (wdtFire) begin
          stateD = ST_HOLD;
        end else if (sleepIn) begin
          stateD = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (pinRise) begin
          stateD = ST_OST;
        end else if (wakeEv) begin
          stateD = cfgQ.xtal ? ST_WAKE : ST_RUN;
        end
      end
      ST_WAKE:  stateD = ostDone ? ST_RUN : ST_WAKE;
      default:  stateD = ST_HOLD;
    endcase
    if (porLow || borRstQ) begin
      stateD = ST_HOLD;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ <= ST_HOLD;
    end else begin
      stateQ <= stateD;
    end
  end

  // cause and flags; supply resets take priority over pin and watchdog
  always_ff @(posedge clk) begin
    if (rst || porLow) begin
      causeQ <= CS_POR;
      toQ    <= 1'b1;
      pdQ    <= 1'b1;
    end else if (borRstQ) begin
      causeQ <= CS_BOR;
      toQ    <= 1'b1;
      pdQ    <= 1'b1;
    end else if (pinRise && (stateQ == ST_RUN || sleeping)) begin
      causeQ <= sleeping ? CS_PIN_SLEEP : CS_PIN_RUN;
      if (sleeping) begin
        toQ <= 1'b1;
        pdQ <= 1'b0;
      end
    end else if (wdtFire && (stateQ == ST_RUN || sleeping)) begin
      causeQ <= sleeping ? CS_WDT_SLEEP : CS_WDT_RUN;
      toQ    <= 1'b0;
      pdQ    <= !sleeping;
    end else if (stateQ == ST_RUN && sleepIn) begin
      toQ <= 1'b1;
      pdQ <= 1'b0;
    end else if (clrWdtIn || cmdClr) begin
      toQ <= 1'b1;
      pdQ <= 1'b1;
    end
  end

  // wake outputs: one-cycle pulses when the core resumes after sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeIrqQ <= 1'b0;
      resumeQ  <= 1'b0;
      vectorQ  <= 1'b0;
    end else begin
      if (wakeEv) begin
        wakeIrqQ <= !wdtFire;
      end
      resumeQ <= stateD == ST_RUN && (stateQ == ST_SLEEP || stateQ == ST_WAKE);
      vectorQ <= stateD == ST_RUN && (stateQ == ST_SLEEP || stateQ == ST_WAKE) &&
                 (sleeping ? !wdtFire : wakeIrqQ) && gieIn;
    end
  end

  // registered reset lines so every core flop leaves reset on one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      coreRstQ  <= 1'b1;
      porRstQ   <= 1'b1;
      sleepingQ <= 1'b0;
    end else begin
      coreRstQ  <= (stateQ inside {ST_HOLD, ST_POWERUP_DELAY_TIMER, ST_OST}) || pinRstQ;
      porRstQ   <= (stateQ inside {ST_HOLD, ST_POWERUP_DELAY_TIMER, ST_OST}) && causeQ == CS_POR;
      sleepingQ <= sleeping || stateQ == ST_WAKE;
    end
  end

  // pin stays an input: output and enable are held low for good
  always_ff @(posedge clk) begin
    if (rst) begin
      borEnQ        <= 1'b0;
      borLevelQ     <= 1'b0;
      extPinOutQ    <= 1'b0;
      extPinOeQ     <= 1'b0;
      extPinPullupQ <= 1'b0;
    end else begin
      borEnQ        <= borOn;
      borLevelQ     <= flashEraseIn ? 1'b0 : cfgQ.borLevel;
      extPinOutQ    <= 1'b0;
      extPinOeQ     <= 1'b0;
      extPinPullupQ <= cfgQ.extPinSel;
    end
  end

  // AXI4-Lite write channel: address and data accepted in either order
  wire awHaveD = (awHaveQ && !wrGo) || (awvalid && awready);
  wire wHaveD  = (wHaveQ && !wrGo) || (wvalid && wready);
  wire bvalidD = wrGo || (bvalid && !bready);
  wire wrMap   = awAddrQ inside {ADDR_CFG, ADDR_OPT, ADDR_PCON, ADDR_STAT, ADDR_CMD};

  always_ff @(posedge clk) begin
    if (rst) begin
      awHaveQ <= 1'b0;
      wHaveQ  <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= '0;
      wStrb0Q <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awHaveQ <= awHaveD;
      wHaveQ  <= wHaveD;
      bvalid  <= bvalidD;
      awready <= !awHaveD && !bvalidD;
      wready  <= !wHaveD && !bvalidD;
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wDataQ  <= wdata;
        wStrb0Q <= wstrb[0];
      end
      if (wrGo) begin
        bresp <= wrMap ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  wire wrLow = wrGo && wStrb0Q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfgQ <= CFG_RST;
      optQ <= OPT_RST;
    end else begin
      if (wrLow && awAddrQ == ADDR_CFG) begin
        cfgQ <= rss_cfg_t'(wDataQ[6:0]);
      end
      if (wrLow && awAddrQ == ADDR_OPT) begin
        optQ <= wDataQ[3:0];
      end
    end
  end

  // status bits: hardware clear wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pconQ <= PCON_RST;
    end else begin
      if (wrLow && awAddrQ == ADDR_PCON) begin
        pconQ <= wDataQ[1:0];
      end
      if (porLow) begin
        pconQ[PCON_POR_BIT] <= 1'b0;
      end
      if (borRstQ && !porLow) begin
        pconQ[PCON_BOR_BIT] <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (araddr)
      ADDR_CFG:  rdMux[6:0] = cfgQ;
      ADDR_OPT:  rdMux[3:0] = optQ;
      ADDR_PCON: rdMux[1:0] = pconQ;
      ADDR_STAT: begin
        rdMux[STAT_TO_BIT] = toQ;
        rdMux[STAT_PD_BIT] = pdQ;
        rdMux[STAT_CAUSE_LSB +: 3] = causeQ;
        rdMux[STAT_STATE_LSB +: 3] = stateQ;
      end
      default:   rdMux = 32'h0000_0000;
    endcase
  end

  wire rvalidD = (arvalid && arready) || (rvalid && !rready);
  wire rdMap   = araddr inside {ADDR_CFG, ADDR_OPT, ADDR_PCON, ADDR_STAT, ADDR_CMD};

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      rvalid  <= rvalidD;
      arready <= !rvalidD;
      if (arvalid && arready) begin
        rdata <= rdMux;
        rresp <= rdMap ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule : rss_reset_sequencer
`default_nettype wire

/* test/rss_reset_checker.sv */
// checker: timing relations at the reset sequencer's ports
// assumes bind onto rss_reset_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rss_reset_checker
  import rss_pkg::*;
#(
  parameter int unsigned OSC_DIV_P = OSC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic porOkIn,
  input wire logic lowSupplyIn,
  input wire logic extResetPinIn,
  input wire logic flashEraseIn,
  input wire logic coreRstQ,
  input wire logic resumeQ,
  input wire logic vectorQ,
  input wire logic sleepingQ,
  input wire logic borEnQ,
  input wire logic borLevelQ,
  input wire logic extPinOutQ,
  input wire logic extPinOeQ,
  input wire logic extPinPullupQ
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [9:0] lowCnt_q;
  logic [9:0] pinCnt_q;

  // saturating run lengths; margins cover the synchronisers and filters
  always_ff @(posedge clk) begin
    if (rst || !(borEnQ && lowSupplyIn)) lowCnt_q <= 10'h0;
    else if (lowCnt_q != 10'h3ff) lowCnt_q <= lowCnt_q + 10'h1;
  end

  always_ff @(posedge clk) begin
    if (rst || extResetPinIn || !extPinPullupQ) pinCnt_q <= 10'h0;
    else if (pinCnt_q != 10'h3ff) pinCnt_q <= pinCnt_q + 10'h1;
  end

  sequence supplyLost;
    !porOkIn [*7];
  endsequence

  sequence wakeStep;
    sleepingQ ##1 resumeQ;
  endsequence

  a_pin_undriven: assert property (!extPinOeQ && !extPinOutQ)
    else $error("reset pin driven");
  a_supply_holds: assert property (supplyLost |-> coreRstQ)
    else $error("core runs without supply");
  a_brownout_resets: assert property (lowCnt_q > 10'd260 |-> coreRstQ)
    else $error("long low supply did not reset");
  a_pin_resets: assert property (pinCnt_q > 10'd520 |-> coreRstQ)
    else $error("long pin low did not reset");
  a_flash_forces: assert property (flashEraseIn && $past(flashEraseIn) |-> borEnQ && !borLevelQ)
    else $error("flash erase not forcing brown-out");
  a_vector_paired: assert property (vectorQ |-> resumeQ)
    else $error("vector without resume");
  a_resume_pulse: assert property (resumeQ |=> !resumeQ)
    else $error("resume longer than one cycle");
  a_wake_no_reset: assert property (wakeStep |-> !coreRstQ)
    else $error("wake reset the core");
  a_wake_from_sleep: assert property (resumeQ |-> sleepingQ)
    else $error("resume outside sleep");
endmodule : rss_reset_checker

bind rss_reset_sequencer rss_reset_checker #(.OSC_DIV_P(OSC_DIV_P)) i_rss_reset_checker (
  .clk, .rst, .porOkIn, .lowSupplyIn, .extResetPinIn, .flashEraseIn, .coreRstQ, .resumeQ,
  .vectorQ, .sleepingQ, .borEnQ, .borLevelQ, .extPinOutQ, .extPinOeQ, .extPinPullupQ);
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the reset source sequencer
// assumes the design alone at its ports, slow oscillator divider shortened to 4
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rss_pkg::*;
  localparam int unsigned DIV = 4;
  localparam int unsigned UP = POWERUP_DELAY_TIMER_TICKS * DIV;
  logic        clk, rst, porOkIn, lowSupplyIn, extResetPinIn, sleepIn, clrWdtIn, oscFailIn;
  logic        flashEraseIn, irqWakeIn, gieIn, coreRstQ, porRstQ, resumeQ, vectorQ;
  logic        sleepingQ, borEnQ, borLevelQ, extPinOutQ, extPinOeQ, extPinPullupQ;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          mismatches, num_checks, cyc;

  rss_reset_sequencer #(.OSC_DIV_P(DIV)) i_rss_reset_sequencer (
    .clk, .rst, .porOkIn, .lowSupplyIn, .extResetPinIn, .sleepIn, .clrWdtIn, .oscFailIn,
    .flashEraseIn, .irqWakeIn, .gieIn, .coreRstQ, .porRstQ, .resumeQ, .vectorQ,
    .sleepingQ, .borEnQ, .borLevelQ, .extPinOutQ, .extPinOeQ, .extPinPullupQ,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // whole run is about 21k cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chkBit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask : chkBit

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chkWord

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chkBit(bresp === RESP_OKAY, 1'b1, "write response");
    bready <= 1'b0;
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRd

  task automatic chkStat(input rss_cause_t c, input logic to, input logic pd);
    logic [31:0] d;
    logic [1:0]  r;
    axiRd(ADDR_STAT, d, r);
    chkWord(d & 32'h0000_0718, (32'(c) << STAT_CAUSE_LSB) | (32'(to) << STAT_TO_BIT)
            | (32'(pd) << STAT_PD_BIT), "status cause and flags");
  endtask : chkStat

  task automatic waitCore(input logic lvl, input int maxCyc);
    int n;
    n = 0;
    while (coreRstQ !== lvl && n < maxCyc) begin
      @(posedge clk);
      n++;
    end
    chkBit(coreRstQ, lvl, "core reset level");
  endtask : waitCore

  task automatic goSleep();
    @(posedge clk);
    sleepIn <= 1'b1;
    @(posedge clk);
    sleepIn <= 1'b0;
  endtask : goSleep

  // resume stands one cycle: sampled at the edge that ends it
  task automatic waitResume(input int maxCyc, output logic vec);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (resumeQ !== 1'b1 && n < maxCyc);
    chkBit(resumeQ, 1'b1, "resume pulse");
    chkBit(coreRstQ, 1'b0, "core kept running on wake");
    vec = vectorQ;
  endtask : waitResume

  task automatic testPowerUp();
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    porOkIn <= 1'b0;
    tick(10);
    porOkIn <= 1'b1;
    chkBit(coreRstQ, 1'b1, "held without supply");
    chkBit(porRstQ, 1'b1, "power-on class held");
    t0 = cyc;
    axiRd(ADDR_CFG, d, r);
    chkWord(d, 32'(CFG_RST), "cfg reset");
    axiRd(ADDR_OPT, d, r);
    chkWord(d, 32'(OPT_RST), "opt reset");
    axiRd(ADDR_PCON, d, r);
    chkWord(d, 32'h1, "pcon after power-on");
    axiRd(8'h14, d, r);
    chkWord(d, 32'h0, "unmapped reads zero");
    chkBit(r === RESP_SLVERR, 1'b1, "unmapped refused");
    waitCore(1'b0, 6000);
    chkBit(porRstQ, 1'b0, "power-on class released");
    chkBit(cyc - t0 >= UP, 1'b1, "start-up length");
    chkStat(CS_POR, 1'b1, 1'b1);
    chkBit(extPinPullupQ, 1'b1, "pull-up on");
  endtask : testPowerUp

  task automatic testBrownOut();
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    axiWr(ADDR_PCON, 32'h3);
    lowSupplyIn <= 1'b1;
    tick(300);
    chkBit(coreRstQ, 1'b1, "brown-out reset");
    chkBit(porRstQ, 1'b0, "retained kept on brown-out");
    lowSupplyIn <= 1'b0;
    tick(1500);
    chkBit(coreRstQ, 1'b1, "delay running");
    lowSupplyIn <= 1'b1;
    tick(300);
    lowSupplyIn <= 1'b0;
    t0 = cyc;
    waitCore(1'b0, 6000);
    chkBit(cyc - t0 >= UP, 1'b1, "delay restarted in full");
    chkStat(CS_BOR, 1'b1, 1'b1);
    axiRd(ADDR_PCON, d, r);
    chkWord(d, 32'h2, "pcon after brown-out");
  endtask : testBrownOut

  task automatic testWatchdog();
    int   t0;
    logic v;
    axiWr(ADDR_CFG, 32'h5b);
    axiWr(ADDR_OPT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      tick(600);
      if (i == 0) clrWdtIn <= 1'b1;
      else if (i == 1) oscFailIn <= 1'b1;
      else axiWr(ADDR_CMD, 32'h1);
      tick(1);
      clrWdtIn <= 1'b0;
      oscFailIn <= 1'b0;
      chkBit(coreRstQ, 1'b0, "watchdog cleared");
    end
    t0 = cyc;
    waitCore(1'b1, 1500);
    chkBit(cyc - t0 >= WDT_TICKS * DIV - 8, 1'b1, "watchdog period");
    t0 = cyc;
    waitCore(1'b0, 3000);
    chkBit(cyc - t0 < POWERUP_DELAY_TIMER_TICKS * DIV, 1'b1, "no power-up delay");
    chkBit(cyc - t0 >= OST_CYC, 1'b1, "start-up count held");
    chkStat(CS_WDT_RUN, 1'b0, 1'b1);
    goSleep();
    tick(4);
    irqWakeIn <= 1'b1;
    t0 = cyc;
    waitResume(1500, v);
    irqWakeIn <= 1'b0;
    chkBit(cyc - t0 >= OST_CYC, 1'b1, "crystal wake waits for count");
    axiWr(ADDR_CFG, 32'h1b);
  endtask : testWatchdog

  task automatic testWakes();
    logic v;
    axiWr(ADDR_OPT, 32'h0);
    goSleep();
    tick(2);
    chkBit(sleepingQ, 1'b1, "asleep");
    waitResume(1500, v);
    chkBit(v, 1'b0, "no vector on watchdog wake");
    chkStat(CS_WDT_SLEEP, 1'b0, 1'b0);
    axiWr(ADDR_CFG, 32'h1a);
    axiWr(ADDR_OPT, 32'hf);
    tick(1500);
    chkBit(coreRstQ, 1'b0, "watchdog off");
    for (int g = 0; g < 2; g++) begin
      goSleep();
      tick(4);
      irqWakeIn <= 1'b1;
      gieIn <= g[0];
      waitResume(50, v);
      chkBit(v, g[0], "vector on enabled wake");
      irqWakeIn <= 1'b0;
    end
  endtask : testWakes

  task automatic testPin();
    extResetPinIn <= 1'b0;
    tick(200);
    extResetPinIn <= 1'b1;
    tick(20);
    chkBit(coreRstQ, 1'b0, "short pulse ignored");
    goSleep();
    for (int k = 0; k < 2; k++) begin
      extResetPinIn <= 1'b0;
      tick(700);
      chkBit(coreRstQ, 1'b1, "pin reset");
      chkBit(extPinOeQ, 1'b0, "pin never driven");
      extResetPinIn <= 1'b1;
      waitCore(1'b0, 2000);
      chkStat(k == 0 ? CS_PIN_SLEEP : CS_PIN_RUN, 1'b1, 1'b0);
    end
    axiWr(ADDR_CFG, 32'h18);
    tick(2);
    chkBit(extPinPullupQ, 1'b0, "pull-up off");
    extResetPinIn <= 1'b0;
    tick(700);
    chkBit(coreRstQ, 1'b0, "pin ignored");
    extResetPinIn <= 1'b1;
    tick(2);
  endtask : testPin

  task automatic testBrownModes();
    logic [1:0] mode;
    logic       lvl;
    logic       v;
    for (int m = 0; m < 3; m++) begin
      mode = (m == 0) ? 2'b11 : (m == 1) ? 2'b10 : 2'b00;
      lvl = (m != 1);
      axiWr(ADDR_CFG, {25'h0, 1'b0, lvl, mode, 3'b010});
      tick(3);
      chkBit(borEnQ, mode[1], "brown-out enable in run");
      chkBit(borLevelQ, lvl, "brown-out level");
      goSleep();
      tick(3);
      chkBit(borEnQ, mode == 2'b11, "brown-out enable asleep");
      irqWakeIn <= 1'b1;
      waitResume(50, v);
      irqWakeIn <= 1'b0;
    end
    flashEraseIn <= 1'b1;
    tick(3);
    chkBit(borEnQ, 1'b1, "erase forces enable");
    chkBit(borLevelQ, 1'b0, "erase forces lowest level");
    flashEraseIn <= 1'b0;
  endtask : testBrownModes

  initial begin
    {rst, porOkIn, extResetPinIn} = 3'h7;
    {lowSupplyIn, sleepIn, clrWdtIn, oscFailIn, flashEraseIn, irqWakeIn, gieIn} = 7'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    mismatches = 0;
    num_checks = 0;
    cyc = 0;
    tick(3);
    rst <= 1'b0;
    tick(2);
    testPowerUp();
    testBrownOut();
    testWatchdog();
    testWakes();
    testPin();
    testBrownModes();
    summarize();
  end
endmodule : testbench
`default_nettype wire
